// ===== hw/ext_irq_ctrl.sv
/*
  Central and external interrupt control: registers on classic Wishbone,
  eight external channels, top-level gating, five-cycle arbitration, nested
  hold levels and the sixteen-line wake/interrupt extension feeding D1.
  Assumes the CPU pulses cpuAck.ack only while irqOut.req is high, and that
  all pins are synchronous to ref_clk.
*/
// How it works
// - Central bit 7 drives the multifunction timer enable output.
// - Top pending set by event or software one, cleared on top acknowledge.
// - Select one: needs pending plus enable or unmaskable; select zero: pending plus unmaskable.
// - Enable cleared by entry, set by return, except top; EI/DI too.
// - Arbitration mode: zero concurrent, one nested; only software changes it.
// - Three-bit current priority, zero highest; nested hardware updates it.
// - Per-channel edge bit: zero falling, one rising; D1 bit7, A0 bit0.
// - Channel pending set on edge or software one, cleared on acknowledge.
// - Channel mask zero blocks; one allows request when pending and enable.
// - Pair priority: two register bits high, channel index as low bit.
// - Vector upper nibble forms vector with channel; not reset.
// - Top edge bit: zero falling, one rising on the unmaskable input.
// - Top source bit: zero watchdog end of count, one unmaskable input.
// - A0 source bit: zero watchdog end of count, one external pin.
// - Wait enable bit gates the memory wait input.
// - Unmaskable bit set by software, cleared only by reset.
// - Nested: hold bit set on preemption, cleared when return resumes it.
// - Sixteen extra lines act as the D1 channel source.
// - Each extra line has its own mask and edge polarity; mode selectable.
// - Source select swaps D1 from standard pin to extra lines.
// - Arbitration samples pending requests once every five cycles.
module ext_irq_ctrl
  import ext_irq_pkg::*;
#(
  parameter int ADR_W = 10,
  parameter int WAKE_LINES = 16
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] extPins,
  input wire logic nmiPin,
  input wire logic watchdogEoc,
  input wire logic [WAKE_LINES-1:0] wakeLines,
  input wire logic memWaitPin,
  input wire cpu_ack_t cpuAck,
  output irq_req_t irqOut,
  output logic timerEnable,
  output logic memWaitStretch,
  output logic wakeupEvent
);

  // Lowest set hold bit is the most recently preempted routine
  function automatic logic [2:0] lowestSet(input logic [6:0] v);
    logic [2:0] r;
    r = PRIO_LOWEST;
    for (int i = 6; i >= 0; i--)
    begin
      if (v[i])
        r = 3'(i);
    end
    return r;
  endfunction

  // Three-bit priority of channel k from the pair register
  function automatic logic [2:0] chanPrio(input logic [7:0] pl, input int k);
    return {pl[2 * (k / 2) + 1], pl[2 * (k / 2)], k[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic ack_ff;
  logic [31:0] rdData_ff;
  logic cntEn_ff, topPend_ff, tlSel_ff, irqEn_ff, arbMode_ff;
  logic [2:0] curPrio_ff;
  logic [7:0] edge_ff, pend_ff, mask_ff, prio_ff;
  logic [3:0] vecHi_ff;
  logic [3:0] vecLo_ff;
  logic unmask_ff;
  logic [6:0] hold_ff;
  logic [1:0] wakeCtrl_ff;
  logic [WAKE_LINES-1:0] wakeMask_ff, wakeEdge_ff, wakePend_ff;
  logic [2:0] arbCnt_ff;
  irq_req_t irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave decode

  wire [7:0] regIdx = wb_adr_i[9:2];
  wire busReq = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  wire wbWrite = busReq & wb_we_i & ack_ff & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire wrCentral = wbWrite & (regIdx == IDX_CENTRAL);
  wire wrEdge = wbWrite & (regIdx == IDX_EDGE);
  wire wrPend = wbWrite & (regIdx == IDX_PEND);
  wire wrMask = wbWrite & (regIdx == IDX_MASK);
  wire wrPrio = wbWrite & (regIdx == IDX_PRIO);
  wire wrVector = wbWrite & (regIdx == IDX_VECTOR);
  wire wrNested = wbWrite & (regIdx == IDX_NESTED);
  wire wrWakeCtrl = wbWrite & (regIdx == IDX_WAKE_CTRL);
  wire wrWMaskLo = wbWrite & (regIdx == IDX_WAKE_MASK_LO);
  wire wrWMaskHi = wbWrite & (regIdx == IDX_WAKE_MASK_HI);
  wire wrWEdgeLo = wbWrite & (regIdx == IDX_WAKE_EDGE_LO);
  wire wrWEdgeHi = wbWrite & (regIdx == IDX_WAKE_EDGE_HI);
  wire wrWPendLo = wbWrite & (regIdx == IDX_WAKE_PEND_LO);
  wire wrWPendHi = wbWrite & (regIdx == IDX_WAKE_PEND_HI);

  wire [7:0] centralRd = {cntEn_ff, topPend_ff, tlSel_ff, irqEn_ff, arbMode_ff, curPrio_ff};
  // Read select; unmapped indices read zero but still acknowledge
  wire [7:0] rdByte =
    (regIdx == IDX_CENTRAL) ? centralRd :
    (regIdx == IDX_EDGE) ? edge_ff :
    (regIdx == IDX_PEND) ? pend_ff :
    (regIdx == IDX_MASK) ? mask_ff :
    (regIdx == IDX_PRIO) ? prio_ff :
    (regIdx == IDX_VECTOR) ? {vecHi_ff, vecLo_ff} :
    (regIdx == IDX_NESTED) ? {unmask_ff, hold_ff} :
    (regIdx == IDX_WAKE_CTRL) ? {6'h00, wakeCtrl_ff} :
    (regIdx == IDX_WAKE_MASK_LO) ? wakeMask_ff[7:0] :
    (regIdx == IDX_WAKE_MASK_HI) ? wakeMask_ff[15:8] :
    (regIdx == IDX_WAKE_EDGE_LO) ? wakeEdge_ff[7:0] :
    (regIdx == IDX_WAKE_EDGE_HI) ? wakeEdge_ff[15:8] :
    (regIdx == IDX_WAKE_PEND_LO) ? wakePend_ff[7:0] :
    (regIdx == IDX_WAKE_PEND_HI) ? wakePend_ff[15:8] : 8'h00;

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ack_ff <= 1'b0;
      rdData_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= busReq & ~ack_ff;
      if (busReq & ~ack_ff)
        rdData_ff <= {24'h00_0000, rdByte};
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdData_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sources and edge detection

  wire tlEdgeSel = vecLo_ff[B_TLEDGE];
  wire tlSrcSel = vecLo_ff[B_TLSRC];
  wire a0SrcSel = vecLo_ff[B_A0SRC];
  wire d1SrcSel = wakeCtrl_ff[B_D1SRC];
  wire wakeModeSel = wakeCtrl_ff[B_WAKEMODE];

  wire [WAKE_LINES-1:0] wakeTrig;
  wire wakeAny = |(wakePend_ff & wakeMask_ff);
  wire d1Src = d1SrcSel ? wakeAny : extPins[7];
  wire a0Src = a0SrcSel ? extPins[0] : watchdogEoc;
  wire [7:0] chanSrc = {d1Src, extPins[6:1], a0Src};
  wire [7:0] chanTrig;
  // Watchdog end of count is taken on its rising edge
  wire tlSrc = tlSrcSel ? nmiPin : watchdogEoc;
  wire tlPol = tlSrcSel ? tlEdgeSel : 1'b1;
  wire tlTrig;

  edge_detect #(.W(8)) chanEdges (
    .ref_clk(ref_clk),
    .reset(reset),
    .sigIn(chanSrc),
    .risingSel(edge_ff),
    .trig(chanTrig)
  );

  edge_detect #(.W(1)) topEdge (
    .ref_clk(ref_clk),
    .reset(reset),
    .sigIn(tlSrc),
    .risingSel(tlPol),
    .trig(tlTrig)
  );

  edge_detect #(.W(WAKE_LINES)) wakeEdges (
    .ref_clk(ref_clk),
    .reset(reset),
    .sigIn(wakeLines),
    .risingSel(wakeEdge_ff),
    .trig(wakeTrig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  // Request gating for the top level
  wire topReq = topPend_ff & (unmask_ff | (tlSel_ff & irqEn_ff));
  wire [7:0] cand = pend_ff & mask_ff & {8{irqEn_ff}};

  logic anyCand;
  logic [2:0] winChan;
  logic [2:0] winPrio;
  // Lowest priority number wins; ties go to the lower channel index
  always_comb
  begin
    anyCand = 1'b0;
    winChan = 3'h0;
    winPrio = PRIO_LOWEST;
    for (int k = 0; k < 8; k++)
    begin
      if (cand[k] && (!anyCand || chanPrio(prio_ff, k) < winPrio))
      begin
        anyCand = 1'b1;
        winChan = 3'(k);
        winPrio = chanPrio(prio_ff, k);
      end
    end
  end

  wire grantChan = anyCand & (winPrio < curPrio_ff);
  wire arbTick = (arbCnt_ff == ARB_PERIOD_M1);
  wire ackTake = cpuAck.ack & irq_ff.req;
  wire ackTop = ackTake & irq_ff.top;
  wire ackChan = ackTake & ~irq_ff.top;
  wire iretChan = cpuAck.iret & ~cpuAck.iretTop;
  wire nested = arbMode_ff;
  wire [2:0] resumeLvl = lowestSet(hold_ff);
  wire [7:0] ackClr = ackChan ? (8'h01 << irq_ff.chan) : 8'h00;

  // Five-cycle sampling divider
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      arbCnt_ff <= 3'h0;
    else
      arbCnt_ff <= arbTick ? 3'h0 : arbCnt_ff + 3'h1;
  end

  // Grant stands until acknowledged or the next sample; ack wins over a tick
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq_ff <= '0;
    else if (ackTake)
      irq_ff.req <= 1'b0;
    else if (arbTick)
    begin
      irq_ff.req <= topReq | grantChan;
      irq_ff.top <= topReq;
      irq_ff.chan <= winChan;
      irq_ff.prio <= winPrio;
      irq_ff.vector <= {vecHi_ff, winChan, 1'b0};
    end
  end

  assign irqOut = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Central control and nested state next values

  wire nxt_topPend = tlTrig | (wrCentral & wd[B_TOP_PEND]) | (topPend_ff & ~ackTop);
  // Explicit write beats flow strobes; entry and return skip the top level
  wire nxt_irqEn = wrCentral ? wd[B_IRQ_EN] :
                   cpuAck.ei ? 1'b1 :
                   cpuAck.di ? 1'b0 :
                   ackChan ? 1'b0 :
                   iretChan ? 1'b1 : irqEn_ff;
  wire [2:0] nxt_curPrio = wrCentral ? wd[2:0] :
                           (nested & ackChan) ? irq_ff.prio :
                           (nested & iretChan) ? resumeLvl : curPrio_ff;
  // Shift past bit six yields zero, so level seven holds nothing
  wire [6:0] holdSet = (nested & ackChan) ? (7'h01 << curPrio_ff) : 7'h00;
  wire [6:0] holdClr = (nested & iretChan) ? (7'h01 << resumeLvl) : 7'h00;
  wire [6:0] nxt_hold = (hold_ff & ~holdClr) | holdSet;
  // Pending: write stores the byte; a same-cycle edge still wins
  wire [7:0] nxt_pend = chanTrig | (wrPend ? wd : (pend_ff & ~ackClr));
  wire [WAKE_LINES-1:0] wakeSet = wakeTrig & {WAKE_LINES{d1SrcSel}};
  wire [WAKE_LINES-1:0] wakeWr = {wrWPendHi ? wd : wakePend_ff[15:8],
                                  wrWPendLo ? wd : wakePend_ff[7:0]};
  wire [WAKE_LINES-1:0] nxt_wakePend = wakeSet | wakeWr;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      {cntEn_ff, topPend_ff, tlSel_ff, irqEn_ff, arbMode_ff, curPrio_ff} <= RST_CENTRAL;
      hold_ff <= 7'h00;
      pend_ff <= 8'h00;
      wakePend_ff <= '0;
    end
    else
    begin
      topPend_ff <= nxt_topPend;
      irqEn_ff <= nxt_irqEn;
      curPrio_ff <= nxt_curPrio;
      hold_ff <= nxt_hold;
      pend_ff <= nxt_pend;
      wakePend_ff <= nxt_wakePend;
      if (wrCentral)
      begin
        cntEn_ff <= wd[B_CNT_EN];
        tlSel_ff <= wd[B_TLSEL];
        arbMode_ff <= wd[B_ARB_MODE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain software registers

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      edge_ff <= 8'h00;
      mask_ff <= 8'h00;
      prio_ff <= RST_PRIO;
      vecLo_ff <= RST_VECTOR_LO;
      unmask_ff <= 1'b0;
      wakeCtrl_ff <= 2'h0;
      wakeMask_ff <= '0;
      wakeEdge_ff <= '0;
    end
    else
    begin
      if (wrEdge)
        edge_ff <= wd;
      if (wrMask)
        mask_ff <= wd;
      if (wrPrio)
        prio_ff <= wd;
      if (wrVector)
        vecLo_ff <= wd[3:0];
      if (wrNested & wd[B_UNMASK])
        unmask_ff <= 1'b1;
      if (wrWakeCtrl)
        wakeCtrl_ff <= wd[1:0];
      if (wrWMaskLo)
        wakeMask_ff[7:0] <= wd;
      if (wrWMaskHi)
        wakeMask_ff[15:8] <= wd;
      if (wrWEdgeLo)
        wakeEdge_ff[7:0] <= wd;
      if (wrWEdgeHi)
        wakeEdge_ff[15:8] <= wd;
    end
  end

  // Vector nibble deliberately left without reset
  always_ff @(posedge ref_clk)
  begin
    if (wrVector)
      vecHi_ff <= wd[7:4];
  end

  assign timerEnable = cntEn_ff;
  assign memWaitStretch = memWaitPin & vecLo_ff[B_WAIT_EN];
  // Wake signalling only in wake mode; interrupt path is through D1
  assign wakeupEvent = wakeModeSel & wakeAny;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  timer_enable_a: assert property (wrCentral |=> timerEnable == $past(wd[B_CNT_EN]))
    else $error("timer enable did not follow central write");

  top_ack_clear_a: assert property (ackTop && !tlTrig && !wrCentral |=> !topPend_ff)
    else $error("top pending not cleared on acknowledge");

  top_request_a: assert property (arbTick && !ackTake && topReq |=> irq_ff.req && irq_ff.top)
    else $error("top request not raised at sample");

  enable_entry_a: assert property (ackChan && !wrCentral && !cpuAck.ei |=> !irqEn_ff)
    else $error("enable not cleared by interrupt entry");

  mode_stable_a: assert property (!wrCentral |=> $stable(arbMode_ff))
    else $error("arbitration mode changed without a write");

  grant_strict_a: assert property (arbTick && !ackTake && !topReq && anyCand
      && winPrio >= curPrio_ff |=> !irq_ff.req)
    else $error("granted a request not above current level");

  sample_period_a: assert property (arbTick |=> !arbTick [*4] ##1 arbTick)
    else $error("arbitration period is not five cycles");

  pend_set_a: assert property (|chanTrig |=> (pend_ff & $past(chanTrig)) == $past(chanTrig))
    else $error("channel edge lost");

  hold_push_a: assert property (nested && ackChan && !wrCentral && curPrio_ff != PRIO_LOWEST
      |=> hold_ff[$past(curPrio_ff)] && curPrio_ff == $past(irq_ff.prio))
    else $error("preempted level not held");

endmodule

// ===== pkg/ext_irq_pkg.sv
/*
  Shared constants and carrier types for the external interrupt control
  block: register indices, reset values, bit positions and CPU-side structs.
  Assumes a byte-wide register file seen as one 32-bit word per register.
*/
package ext_irq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CENTRAL = 8'hE6;
  localparam logic [7:0] IDX_EDGE = 8'hF2;
  localparam logic [7:0] IDX_PEND = 8'hF3;
  localparam logic [7:0] IDX_MASK = 8'hF4;
  localparam logic [7:0] IDX_PRIO = 8'hF5;
  localparam logic [7:0] IDX_VECTOR = 8'hF6;
  localparam logic [7:0] IDX_NESTED = 8'hF7;
  localparam logic [7:0] IDX_WAKE_CTRL = 8'hF9;
  localparam logic [7:0] IDX_WAKE_MASK_LO = 8'hFA;
  localparam logic [7:0] IDX_WAKE_MASK_HI = 8'hFB;
  localparam logic [7:0] IDX_WAKE_EDGE_LO = 8'hFC;
  localparam logic [7:0] IDX_WAKE_EDGE_HI = 8'hFD;
  localparam logic [7:0] IDX_WAKE_PEND_LO = 8'hFE;
  localparam logic [7:0] IDX_WAKE_PEND_HI = 8'hFF;

  // Reset values
  localparam logic [7:0] RST_CENTRAL = 8'h87;
  localparam logic [7:0] RST_PRIO = 8'hFF;
  localparam logic [3:0] RST_VECTOR_LO = 4'h6;

  // Central control bit positions
  localparam int B_CNT_EN = 7;
  localparam int B_TOP_PEND = 6;
  localparam int B_TLSEL = 5;
  localparam int B_IRQ_EN = 4;
  localparam int B_ARB_MODE = 3;
  // Vector register low-nibble bit positions
  localparam int B_TLEDGE = 3;
  localparam int B_TLSRC = 2;
  localparam int B_A0SRC = 1;
  localparam int B_WAIT_EN = 0;
  // Nested control and wake control bit positions
  localparam int B_UNMASK = 7;
  localparam int B_D1SRC = 1;
  localparam int B_WAKEMODE = 0;

  localparam logic [2:0] PRIO_LOWEST = 3'h7;
  localparam logic [2:0] ARB_PERIOD_M1 = 3'h4;  // Five-cycle arbitration

  // Acknowledge and flow strobes from the CPU core, one-cycle pulses
  typedef struct packed {
    logic ack;
    logic iret;
    logic iretTop;
    logic ei;
    logic di;
  } cpu_ack_t;

  // Arbitration result presented to the CPU core
  typedef struct packed {
    logic req;
    logic top;
    logic [2:0] chan;
    logic [2:0] prio;
    logic [7:0] vector;
  } irq_req_t;

endpackage

// ===== hw/edge_detect.sv
/*
  Per-bit edge detector with selectable polarity, producing one-cycle pulses.
  Assumes inputs already synchronous to ref_clk.
*/
module edge_detect
  import ext_irq_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] sigIn,
  input wire logic [W-1:0] risingSel,
  output logic [W-1:0] trig
);

  logic [W-1:0] prev_ff;
  logic armed_ff;

  // History register; armed only after one sample so reset gives no edge
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      prev_ff <= '0;
      armed_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= sigIn;
      armed_ff <= 1'b1;
    end
  end

  // Rising where selected, falling elsewhere
  assign trig = {W{armed_ff}} & ((risingSel & sigIn & ~prev_ff) |
                                 (~risingSel & ~sigIn & prev_ff));

endmodule

// ===== tb/cpu_model.sv
/*
  CPU core stand-in: acknowledges each grant after a programmable delay and
  replays return, enable and disable strobes that the bench asks for.
  Assumes the package is compiled first and a single clock domain.
*/
module cpu_model
  import ext_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire irq_req_t irqOut,
  input wire logic [1:0] ackDelay,
  input wire logic [3:0] flowReq,
  output cpu_ack_t cpuAck
);
  logic [1:0] waitCnt;

  //////////////////////////////////////////////////////////////////////////
  // One pulse per grant; zero delay answers in the first cycle it sees
  always_ff @(posedge ref_clk)
  begin
    if (reset || irqOut.req !== 1'b1 || cpuAck.ack)
    begin
      waitCnt <= 2'h0;
      cpuAck.ack <= 1'b0;
    end
    else
    begin
      waitCnt <= waitCnt + 2'h1;
      cpuAck.ack <= (waitCnt == ackDelay);
    end
    {cpuAck.iret, cpuAck.iretTop, cpuAck.ei, cpuAck.di} <= reset ? 4'h0 : flowReq;
  end
endmodule

// ===== tb/test_external_interrupt_control_regs.sv
/*
  Self-checking bench: reset values, edge capture, random arbitration, top
  level, nesting and the wake-line source of the D1 channel.
  Assumes the package, the block and the CPU stand-in are compiled first.
*/
module test_external_interrupt_control_regs import ext_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {logic [8:0] exp; logic [8:0] msk;} note_t;
  localparam logic [7:0] RI [8] = '{IDX_CENTRAL, IDX_EDGE, IDX_PEND, IDX_MASK, IDX_PRIO,
    IDX_VECTOR, IDX_NESTED, 8'h10};
  localparam logic [7:0] RV [8] = '{8'h87, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h06, 8'h00, 8'h00};
  localparam logic [7:0] RM [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF};

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h0;
  logic [31:0] datW = 32'h0;
  logic [31:0] datR;
  logic ack;
  logic [7:0] pins = 8'h0;
  logic nmi = 1'b0;
  logic wdog = 1'b0;
  logic [15:0] wake = 16'h0;
  logic memWait = 1'b1;
  logic [1:0] ackDelay = 2'h0;
  logic [3:0] flowReq = 4'h0;
  cpu_ack_t cpuAck;
  irq_req_t irqOut;
  logic timerEn;
  logic waitStretch;
  logic wakeEv;
  logic [3:0] vh;
  note_t rdQ[$];
  note_t grQ[$];
  int errTotal = 0;
  int totalChecks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  ext_irq_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .extPins(pins), .nmiPin(nmi), .watchdogEoc(wdog), .wakeLines(wake),
    .memWaitPin(memWait), .cpuAck(cpuAck), .irqOut(irqOut), .timerEnable(timerEn),
    .memWaitStretch(waitStretch), .wakeupEvent(wakeEv));

  cpu_model cpu_u (.ref_clk(ref_clk), .reset(reset), .irqOut(irqOut), .ackDelay(ackDelay),
    .flowReq(flowReq), .cpuAck(cpuAck));

  ////////////////////////////////////////////////////////////////////////////
  // Masked compare; an unknown in a watched bit never matches
  task automatic cmp(input string nm, input note_t n, input logic [8:0] s);
    totalChecks++;
    if ((s & n.msk) !== (n.exp & n.msk))
    begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, n.exp & n.msk, s & n.msk);
    end
  endtask

  // Classic single cycle; held until ack is sampled high at a rising edge
  task automatic acc(input logic w, input logic [7:0] idx, d, input logic [7:0] m = 8'hFF);
    if (!w)
      rdQ.push_back({1'b0, d, 1'b0, m});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    datW <= {24'h0, d};
    // No cycle count assumed; only the hang guard ends this wait
    while (ack !== 1'b1)
      @(negedge ref_clk);
    @(posedge ref_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  // One-cycle request for return, enable or disable strobes
  task automatic flow(input logic [3:0] f);
    flowReq <= f;
    @(posedge ref_clk);
    flowReq <= 4'h0;
    @(posedge ref_clk);
  endtask

  // Wait out noted grants, then twelve cycles of quiet
  task automatic drain();
    for (int n = 0; n < 60 && grQ.size() > 0; n++)
      @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
  endtask

  // Winner among pending unmasked channels; strict compare keeps lower index on ties
  function automatic int pick(input logic [7:0] p, m, pr, input logic [2:0] current_priority);
    int best;
    logic [2:0] bp;
    logic [2:0] q;
    best = -1;
    bp = current_priority;
    for (int k = 0; k < 8; k++)
    begin
      q = {pr[2*(k/2)+1 -: 2], k[0]};
      if (p[k] && m[k] && q < bp)
      begin
        best = k;
        bp = q;
      end
    end
    return best;
  endfunction

  task automatic closeOut();
    if (rdQ.size() + grQ.size() > 0)
      errTotal++;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Each read acknowledge or taken grant settles the oldest note
  always @(negedge ref_clk)
  begin
    if (ack === 1'b1 && we === 1'b0)
      cmp("read", rdQ.size() > 0 ? rdQ.pop_front() : '1, {1'b0, datR[7:0]});
    if (cpuAck.ack === 1'b1 && irqOut.req === 1'b1)
      cmp("grant", grQ.size() > 0 ? grQ.pop_front() : '1, {irqOut.top, irqOut.vector});
  end

  // Hang guard, far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    closeOut();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] pe;
    logic [7:0] ma;
    logic [7:0] pr;
    logic [7:0] eg;
    logic [15:0] wm;
    int ch;
    void'($urandom(32'hC790));
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    foreach (RI[i])
      acc(1'b0, RI[i], RV[i], RM[i]);
    @(negedge ref_clk);
    cmp("stretch", {9'h0, 9'h1}, {8'h0, waitStretch});
    @(posedge ref_clk);
    acc(1'b1, IDX_CENTRAL, 8'h07);
    @(negedge ref_clk);
    cmp("timer", {9'h0, 9'h1}, {8'h0, timerEn});
    @(posedge ref_clk);
    acc(1'b1, IDX_CENTRAL, RST_CENTRAL);
    vh = 4'($urandom);
    acc(1'b1, IDX_VECTOR, {vh, 4'h3});
    acc(1'b0, IDX_VECTOR, {vh, 4'h3});
    @(negedge ref_clk);
    cmp("stretch", {9'h1, 9'h1}, {8'h0, waitStretch});
    @(posedge ref_clk);
    // Edge capture, rising then falling on every channel pin
    eg = 8'($urandom);
    acc(1'b1, IDX_EDGE, eg);
    pins <= 8'hFF;
    repeat (3) @(posedge ref_clk);
    acc(1'b0, IDX_PEND, eg);
    acc(1'b1, IDX_PEND, 8'h00);
    pins <= 8'h00;
    repeat (3) @(posedge ref_clk);
    acc(1'b0, IDX_PEND, ~eg);
    // Random concurrent arbitration, slow and prompt acknowledges
    for (int r = 0; r < 12; r++)
    begin
      pe = 8'($urandom);
      ma = 8'($urandom);
      pr = 8'($urandom);
      ackDelay <= 2'($urandom);
      acc(1'b1, IDX_MASK, ma);
      acc(1'b1, IDX_PRIO, pr);
      acc(1'b1, IDX_PEND, pe);
      ch = pick(pe, ma, pr, PRIO_LOWEST);
      if (ch >= 0)
        grQ.push_back({1'b0, vh, 3'(ch), 1'b0, 9'h1FF});
      flow(4'h2);
      drain();
      acc(1'b0, IDX_PEND, ch < 0 ? pe : pe & ~(8'h1 << ch));
      acc(1'b0, IDX_CENTRAL, ch < 0 ? 8'h97 : 8'h87);
      flow(4'h1);
    end
    // Leftover channel requests would win once enable is back
    acc(1'b1, IDX_PEND, 8'h00);
    // Software top level: held off until enable, enable kept on entry
    acc(1'b1, IDX_CENTRAL, 8'hE7);
    drain();
    grQ.push_back({9'h100, 9'h100});
    flow(4'h2);
    drain();
    acc(1'b0, IDX_CENTRAL, 8'hB7);
    flow(4'h1);
    // Unmaskable input, rising edge only
    acc(1'b1, IDX_CENTRAL, RST_CENTRAL);
    acc(1'b1, IDX_NESTED, 8'h80);
    acc(1'b1, IDX_VECTOR, {vh, 4'hF});
    grQ.push_back({9'h100, 9'h100});
    nmi <= 1'b1;
    drain();
    nmi <= 1'b0;
    drain();
    acc(1'b1, IDX_NESTED, 8'h00);
    acc(1'b0, IDX_NESTED, 8'h80);
    // Watchdog end of count feeds both the top level and channel A0
    acc(1'b1, IDX_VECTOR, {vh, 4'h0});
    acc(1'b1, IDX_EDGE, 8'h01);
    acc(1'b1, IDX_PEND, 8'h00);
    grQ.push_back({9'h100, 9'h100});
    wdog <= 1'b1;
    drain();
    wdog <= 1'b0;
    acc(1'b0, IDX_PEND, 8'h01);
    // Nested: A0 at level 4, C1 at 5 waits, B1 at 1 preempts
    acc(1'b1, IDX_CENTRAL, 8'h8F);
    acc(1'b1, IDX_PRIO, 8'hE2);
    acc(1'b1, IDX_MASK, 8'h29);
    acc(1'b1, IDX_PEND, 8'h01);
    grQ.push_back({1'b0, vh, 4'h0, 9'h1FF});
    flow(4'h2);
    drain();
    acc(1'b1, IDX_PEND, 8'h20);
    flow(4'h2);
    drain();
    grQ.push_back({1'b0, vh, 3'h3, 1'b0, 9'h1FF});
    acc(1'b1, IDX_PEND, 8'h28);
    drain();
    acc(1'b0, IDX_CENTRAL, 8'h89);
    acc(1'b0, IDX_NESTED, 8'h90);
    flow(4'h8);
    acc(1'b0, IDX_CENTRAL, 8'h9C);
    acc(1'b0, IDX_NESTED, 8'h80);
    flow(4'h1);
    // Wake lines take over the D1 channel source
    acc(1'b1, IDX_CENTRAL, RST_CENTRAL);
    wm = 16'h1 << ($urandom % 16);
    acc(1'b1, IDX_WAKE_MASK_LO, wm[7:0]);
    acc(1'b1, IDX_WAKE_MASK_HI, wm[15:8]);
    acc(1'b1, IDX_WAKE_EDGE_LO, wm[7:0]);
    acc(1'b1, IDX_WAKE_EDGE_HI, wm[15:8]);
    acc(1'b1, IDX_MASK, 8'h80);
    acc(1'b1, IDX_EDGE, 8'h80);
    acc(1'b1, IDX_PEND, 8'h00);
    acc(1'b1, IDX_WAKE_CTRL, 8'h02);
    pins <= 8'h80;
    repeat (3) @(posedge ref_clk);
    acc(1'b0, IDX_PEND, 8'h00);
    wake <= wm;
    repeat (3) @(posedge ref_clk);
    acc(1'b0, IDX_WAKE_PEND_LO, wm[7:0]);
    acc(1'b0, IDX_WAKE_PEND_HI, wm[15:8]);
    acc(1'b0, IDX_PEND, 8'h80);
    acc(1'b1, IDX_WAKE_CTRL, 8'h03);
    @(negedge ref_clk);
    cmp("wake", {9'h1, 9'h1}, {8'h0, wakeEv});
    closeOut();
  end
endmodule
